// ### ufi_consts.svh
`ifndef UFI_CONSTS_SVH
`define UFI_CONSTS_SVH

`define UFI_ADDR_OUT_FLAGS 8'h04
`define UFI_ADDR_CMN_FLAGS 8'h06
`define UFI_ADDR_OUT_EN 8'h09
`define UFI_ADDR_CMN_EN 8'h0b
`define UFI_ADDR_CTRL 8'h0e

`define UFI_RST_FLAGS 8'h00
`define UFI_RST_OUT_EN 8'h0e
`define UFI_RST_CMN_EN 8'h06
`define UFI_RST_CTRL 8'h00

`define UFI_OUT_MASK 8'h0e
`define UFI_CMN_MASK 8'h0f
`define UFI_CTRL_MASK 8'h03

`define UFI_BIT_SUS 0
`define UFI_BIT_RSU 1
`define UFI_BIT_RST 2
`define UFI_BIT_SOF 3
`define UFI_BIT_OUT_EP1 1
`define UFI_BIT_SUSDET 0
`define UFI_BIT_GIE 1

`define UFI_CLK_KHZ 10000
`define UFI_FRAME_US 1000
`define UFI_FRAME_CYC ((`UFI_FRAME_US * `UFI_CLK_KHZ) / 1000)
`define UFI_GUARD_US 20
`define UFI_GUARD_CYC ((`UFI_GUARD_US * `UFI_CLK_KHZ) / 1000)

`endif

// ### ufi_pkg.sv
package ufi_pkg;
  typedef logic [7:0] ufi_byte_t;
  typedef enum logic [0:0]
  {
    UFI_UNLOCKED = 1'b0,
    UFI_LOCKED = 1'b1
  } ufi_sof_state_t;
endpackage : ufi_pkg

// ### ufi_sof_gen.sv
`timescale 1ns/1ns
`include "ufi_consts.svh"

module ufi_sof_gen #(
  parameter int unsigned FRAME_CYC = `UFI_FRAME_CYC,
  parameter int unsigned GUARD_CYC = `UFI_GUARD_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_sof_token,
  input wire logic i_unlock,
  output logic o_sof_evt
);
  localparam int CW = $clog2(FRAME_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(FRAME_CYC - 1);
  localparam logic [CW-1:0] GLAST = CW'(GUARD_CYC - 1);

  ufi_pkg::ufi_sof_state_t state_r;
  ufi_pkg::ufi_sof_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic synth_r;
  logic synth_nxt;
  logic evt_nxt;

  // Frame time elapsed with no token seen
  wire expired = (state_r == ufi_pkg::UFI_LOCKED) && (cnt_r == LAST);
  // Late token just after a synthesized start is the same frame
  wire absorb = i_sof_token && synth_r;
  wire restart = i_sof_token || expired || i_unlock;

  assign evt_nxt = !i_unlock && ((i_sof_token && !absorb) || expired);
  assign state_nxt = i_unlock ? ufi_pkg::UFI_UNLOCKED :
    (i_sof_token ? ufi_pkg::UFI_LOCKED : state_r);
  assign cnt_nxt = restart ? '0 : CW'(cnt_r + 1'b1);
  assign synth_nxt = (i_unlock || i_sof_token) ? 1'b0 :
    (expired ? 1'b1 : ((cnt_r == GLAST) ? 1'b0 : synth_r));

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= ufi_pkg::UFI_UNLOCKED;
      cnt_r <= '0;
      synth_r <= 1'b0;
      o_sof_evt <= 1'b0;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      synth_r <= synth_nxt;
      o_sof_evt <= evt_nxt;
    end
  end

  sequence s_frame_due;
    i_ce && state_r == ufi_pkg::UFI_LOCKED && cnt_r == LAST && !i_unlock;
  endsequence

  AST_SOF_SYNTH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_frame_due |=> o_sof_evt)
    else $error("Expected frame start not synthesized");
endmodule : ufi_sof_gen

// ### ufi_irq_flags.sv
// Behaviour
// - OUT flags at 0x04, write one to clear: bits 3..1 for endpoints 3..1, rest zero.
// - Common flags at 0x06, write one to clear: frame start, bus reset, resume, suspend.
// - Frame-start flag sets when a frame-start token arrives from the host.
// - Frame-start event synthesized at expected time even if token is lost.
// - Reading either flag register clears all its flags.
// - Interrupt request while any enabled flag is set and global enable on.
// - Each common flag gated by own enable; frame-start enable clear at reset.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`include "ufi_consts.svh"

module ufi_irq_flags #(
  parameter int unsigned FRAME_CYC = `UFI_FRAME_CYC,
  parameter int unsigned GUARD_CYC = `UFI_GUARD_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_out_ep_done,
  input wire logic i_sof_token,
  input wire logic i_bus_reset_sig,
  input wire logic i_resume_sig,
  input wire logic i_suspend_sig,
  input wire logic i_suspended,
  output logic [7:0] o_rdata,
  output logic o_irq
);
  logic rst_meta_r;
  logic rst_n;
  ufi_pkg::ufi_byte_t out_r;
  ufi_pkg::ufi_byte_t out_nxt;
  ufi_pkg::ufi_byte_t cmn_r;
  ufi_pkg::ufi_byte_t cmn_nxt;
  ufi_pkg::ufi_byte_t out_en_r;
  ufi_pkg::ufi_byte_t out_en_nxt;
  ufi_pkg::ufi_byte_t cmn_en_r;
  ufi_pkg::ufi_byte_t cmn_en_nxt;
  ufi_pkg::ufi_byte_t ctrl_r;
  ufi_pkg::ufi_byte_t ctrl_nxt;
  ufi_pkg::ufi_byte_t rdata_nxt;
  logic irq_nxt;
  logic sof_evt;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ufi_sof_gen #(
    .FRAME_CYC(FRAME_CYC),
    .GUARD_CYC(GUARD_CYC)
  ) u_sof_gen (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_sof_token(i_sof_token),
    .i_unlock(i_bus_reset_sig || i_suspend_sig),
    .o_sof_evt(sof_evt)
  );

  wire rd_out = i_rd && hit(i_addr, `UFI_ADDR_OUT_FLAGS);
  wire rd_cmn = i_rd && hit(i_addr, `UFI_ADDR_CMN_FLAGS);
  wire wr_out = i_wr && hit(i_addr, `UFI_ADDR_OUT_FLAGS);
  wire wr_cmn = i_wr && hit(i_addr, `UFI_ADDR_CMN_FLAGS);
  wire wr_out_en = i_wr && hit(i_addr, `UFI_ADDR_OUT_EN);
  wire wr_cmn_en = i_wr && hit(i_addr, `UFI_ADDR_CMN_EN);
  wire wr_ctrl = i_wr && hit(i_addr, `UFI_ADDR_CTRL);

  // Event sources
  wire [7:0] out_set = {4'h0, i_out_ep_done, 1'b0};
  wire sus_set = i_suspend_sig && ctrl_r[`UFI_BIT_SUSDET];
  wire rsu_set = i_resume_sig && i_suspended;
  wire [7:0] cmn_set = {4'h0, sof_evt, i_bus_reset_sig, rsu_set, sus_set};

  // Read clears all, write of one clears that bit; set wins
  wire [7:0] out_clr = rd_out ? 8'hff : (wr_out ? i_wdata : 8'h00);
  wire [7:0] cmn_clr = rd_cmn ? 8'hff : (wr_cmn ? i_wdata : 8'h00);

  assign out_nxt = ((out_r & ~out_clr) | out_set) & `UFI_OUT_MASK;
  assign cmn_nxt = ((cmn_r & ~cmn_clr) | cmn_set) & `UFI_CMN_MASK;
  assign out_en_nxt = wr_out_en ? (i_wdata & `UFI_OUT_MASK) : out_en_r;
  assign cmn_en_nxt = wr_cmn_en ? (i_wdata & `UFI_CMN_MASK) : cmn_en_r;
  assign ctrl_nxt = wr_ctrl ? (i_wdata & `UFI_CTRL_MASK) : ctrl_r;

  // Request follows the flags as they will stand next cycle
  assign irq_nxt = ctrl_nxt[`UFI_BIT_GIE] &&
    (|((out_nxt & out_en_nxt) | (cmn_nxt & cmn_en_nxt)));

  // Pre-clear value is returned by a clearing read
  assign rdata_nxt = !i_rd ? 8'h00 :
    rd_out ? out_r :
    rd_cmn ? cmn_r :
    hit(i_addr, `UFI_ADDR_OUT_EN) ? out_en_r :
    hit(i_addr, `UFI_ADDR_CMN_EN) ? cmn_en_r :
    hit(i_addr, `UFI_ADDR_CTRL) ? ctrl_r : 8'h00;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_r <= `UFI_RST_FLAGS;
      cmn_r <= `UFI_RST_FLAGS;
      out_en_r <= `UFI_RST_OUT_EN;
      cmn_en_r <= `UFI_RST_CMN_EN;
      ctrl_r <= `UFI_RST_CTRL;
    end
    else if (i_ce)
    begin
      out_r <= out_nxt;
      cmn_r <= cmn_nxt;
      out_en_r <= out_en_nxt;
      cmn_en_r <= cmn_en_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      o_rdata <= rdata_nxt;
      o_irq <= irq_nxt;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_out;
    i_ce && rd_out;
  endsequence

  sequence s_read_cmn_quiet;
    i_ce && rd_cmn && cmn_set == 8'h00;
  endsequence

  AST_OUT_SET: assert property (
    i_ce && i_out_ep_done[2] |=> out_r[3] && $past(out_r[0]) == 1'b0)
    else $error("Endpoint 3 completion did not set its flag");

  AST_OUT_RSVD: assert property (
    s_read_out |=> o_rdata[0] == 1'b0 && o_rdata[7:4] == 4'h0)
    else $error("Reserved OUT flag bits read nonzero");

  AST_CMN_READ: assert property (
    i_ce && rd_cmn |=> o_rdata == $past(cmn_r) && o_rdata[7:4] == 4'h0)
    else $error("Common flag read returned wrong value");

  AST_SOF_FLAG: assert property (
    i_ce && sof_evt |=> cmn_r[`UFI_BIT_SOF])
    else $error("Frame start event did not set flag");

  AST_READ_CLEARS: assert property (
    s_read_cmn_quiet ##1 !i_ce [*2] ##0 1'b1 |-> cmn_r == 8'h00)
    else $error("Common flags not cleared by read");

  AST_OUT_CLEARS: assert property (
    i_ce && rd_out && out_set == 8'h00 |=> out_r == 8'h00)
    else $error("OUT flags not cleared by read");

  AST_GIE_OFF: assert property (
    i_ce && !ctrl_r[`UFI_BIT_GIE] && !wr_ctrl |=> !o_irq)
    else $error("Interrupt raised with global enable off");

  AST_IRQ_GATE: assert property (
    o_irq == (ctrl_r[`UFI_BIT_GIE] && (|((out_r & out_en_r) | (cmn_r & cmn_en_r)))))
    else $error("Interrupt output disagrees with gated flags");

  AST_SUS_GATED: assert property (
    i_ce && !ctrl_r[`UFI_BIT_SUSDET] && !cmn_r[`UFI_BIT_SUS] |=> !cmn_r[`UFI_BIT_SUS])
    else $error("Suspend flag set while detection disabled");

  AST_RDATA_IDLE: assert property (
    i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("Read data not zero outside a read");

  AST_OUT_READ: assert property (
    i_ce && rd_out |=> o_rdata == $past(out_r))
    else $error("OUT flag read returned wrong value");

  AST_OUT_EP1_SET: assert property (
    i_ce && i_out_ep_done[0] |=> out_r[`UFI_BIT_OUT_EP1])
    else $error("Endpoint 1 completion did not set its flag");

  AST_RST_SET: assert property (
    i_ce && i_bus_reset_sig |=> cmn_r[`UFI_BIT_RST])
    else $error("Bus reset signaling did not set its flag");

  AST_RSU_SET: assert property (
    i_ce && i_resume_sig && i_suspended |=> cmn_r[`UFI_BIT_RSU])
    else $error("Resume while suspended did not set its flag");

  AST_RSU_GATED: assert property (
    i_ce && !i_suspended && !cmn_r[`UFI_BIT_RSU] |=> !cmn_r[`UFI_BIT_RSU])
    else $error("Resume flag set while not suspended");

  AST_SOF_EN_RESET: assert property (
    $rose(rst_n) |-> cmn_en_r == `UFI_RST_CMN_EN && !cmn_en_r[`UFI_BIT_SOF])
    else $error("Frame start enable not clear after reset");
endmodule : ufi_irq_flags

// ### ufi_host_model.sv
`timescale 1ns/1ns

// Bus-side event source: one pulse per requested event, one cycle after the request
module ufi_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_req,
  output logic o_sof,
  output logic o_rst,
  output logic o_rsu,
  output logic o_sus
);
  always_ff @(posedge i_clk)
  begin
    {o_sof, o_rst, o_rsu, o_sus} <= i_req;
  end
endmodule : ufi_host_model

// ### ufi_irq_flags_test.sv
`timescale 1ns/1ns

module ufi_irq_flags_test;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ce = 1'b1;
  logic [2:0] i_out_ep_done = 3'h0;
  logic i_suspended = 1'b0;
  logic [3:0] host_req = 4'h0;
  logic sof_tok, bus_rst, rsu_sig, sus_sig, o_irq;
  logic [7:0] o_rdata;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int total_checks = 0;
  logic [31:0] rnd;

  ufi_host_model host (.i_clk(i_clk), .i_req(host_req), .o_sof(sof_tok), .o_rst(bus_rst),
    .o_rsu(rsu_sig), .o_sus(sus_sig));
  ufi_irq_flags #(.FRAME_CYC(50), .GUARD_CYC(5)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_out_ep_done(i_out_ep_done), .i_sof_token(sof_tok), .i_bus_reset_sig(bus_rst),
    .i_resume_sig(rsu_sig), .i_suspend_sig(sus_sig), .i_suspended(i_suspended),
    .o_rdata(o_rdata), .o_irq(o_irq));

  initial
  begin
    forever #50 i_clk = ~i_clk;
  end

  task report_and_stop;
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Read data stand in the cycle after the strobe only
  always @(posedge i_clk) rd_seen <= i_rd;
  always @(negedge i_clk)
  begin
    if (rd_seen)
      cmp(o_rdata, exp_q.pop_front());
  end

  task idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd

  task pulse(input logic [3:0] r);
    @(posedge i_clk);
    host_req <= r;
    @(posedge i_clk);
    host_req <= 4'h0;
    idle(4);
  endtask : pulse

  task chk_irq(input logic e);
    @(negedge i_clk);
    total_checks++;
    if (o_irq !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, o_irq, e);
    end
  endtask : chk_irq

  initial
  begin
    repeat (2000) @(posedge i_clk);
    bad_count++;
    report_and_stop;
  end

  initial
  begin
    void'($urandom(6740));
    idle(12);
    i_arst_n <= 1'b1;
    idle(3);
    rd(8'h04, 8'h00);
    rd(8'h06, 8'h00);
    // Frozen: read clear holds and a bus reset pulse is ignored
    i_ce <= 1'b0;
    pulse(4'h4);
    i_ce <= 1'b1;
    rd(8'h06, 8'h00);
    rd(8'h09, 8'h0e);
    rd(8'h0b, 8'h06);
    rd(8'h0e, 8'h00);
    rd(8'h05, 8'h00);
    rnd = $urandom();
    @(posedge i_clk);
    i_out_ep_done <= rnd[2:0];
    @(posedge i_clk);
    i_out_ep_done <= 3'h0;
    idle(2);
    rd(8'h04, {4'h0, rnd[2:0], 1'b0});
    rd(8'h04, 8'h00);
    // Detection off and not suspended: nothing may latch
    pulse(4'h3);
    rd(8'h06, 8'h00);
    wr(8'h0e, 8'h03);
    i_suspended <= 1'b1;
    pulse(4'h7);
    chk_irq(1'b1);
    rd(8'h06, 8'h07);
    idle(2);
    chk_irq(1'b0);
    // Endpoint flags raise the request; write of one clears endpoint 1
    @(posedge i_clk);
    i_out_ep_done <= {rnd[4:3], 1'b1};
    @(posedge i_clk);
    i_out_ep_done <= 3'h0;
    idle(2);
    chk_irq(1'b1);
    wr(8'h04, 8'h02);
    rd(8'h04, {4'h0, rnd[4:3], 2'b00});
    idle(2);
    chk_irq(1'b0);
    i_suspended <= 1'b0;
    pulse(4'h8);
    rd(8'h06, 8'h08);
    // No further tokens: the frame timer must fill in
    idle(55);
    chk_irq(1'b0);
    wr(8'h0b, 8'h0f);
    idle(2);
    chk_irq(1'b1);
    rd(8'h06, 8'h08);
    idle(3);
    report_and_stop;
  end
endmodule : ufi_irq_flags_test
